// file: include/rti_pkg.sv
// Package with constants and carriers for the serial register target.
package rti_pkg;

  // ----------------------------------------------------------------
  // Bus identity and framing
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR  = 7'h68;
  localparam logic       DIR_READ     = 1'b1;
  localparam int         BITS_BYTE    = 8;
  localparam logic [7:0] TEST_ADDR_LO = 8'h49;
  localparam logic [7:0] TEST_ADDR_HI = 8'h4A;
  localparam logic [7:0] PTR_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rti_wr_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } rti_pins_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_TX_ACK,
    ST_WAIT_STOP
  } rti_state_e;

endpackage : rti_pkg

// file: verilog/rti_sync.sv
// Two-flop synchroniser for the bus pins.
`timescale 1ns/100ps
`default_nettype none

module rti_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1   <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : rti_sync

`default_nettype wire

// file: verilog/rti_fifo.sv
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none

module rti_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("rti_fifo: DEPTH must be a power of two of at least 2.");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule : rti_fifo

`default_nettype wire

// file: verilog/rti_target.sv
// Serial register target: byte engine, address match and pointer.
//
// How it works
// - Receiver acknowledges each byte, active low.
// - After 8th fall, transmitter releases, receiver acks.
// - Release data at 9th fall for next byte.
// - After no acknowledge, release and await stop.
// - Respond only to own 7-bit address.
// - Address byte D0 writes, D1 reads.
// - No limit on bytes per transaction.
// - Pointer advances after every data byte; a write byte refused while the buffer is full leaves it unchanged.
`timescale 1ns/100ps
`default_nettype none

module rti_target #(
  parameter int FIFO_DEPTH = rti_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  output var  logic       wr_valid,
  input  wire logic       wr_ready,
  output var  logic [7:0] wr_addr,
  output var  logic [7:0] wr_data,
  output var  logic [7:0] rd_addr,
  input  wire logic [7:0] rd_data,
  output var  logic       test_access,
  output var  logic       busy
);

  // ----------------------------------------------------------------
  // Pin sampling and condition detection
  // ----------------------------------------------------------------
  rti_pkg::rti_pins_s pins;
  rti_pkg::rti_pins_s pins_q;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_cond;
  logic               stop_cond;

  rti_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
      pins_q <= '1;
    else
      pins_q <= pins;
  end

  assign scl_rise   = pins.scl && !pins_q.scl;
  assign scl_fall   = !pins.scl && pins_q.scl;
  assign start_cond = pins.scl && pins_q.scl && !pins.sda && pins_q.sda;
  assign stop_cond  = pins.scl && pins_q.scl && pins.sda && !pins_q.sda;

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  rti_pkg::rti_wr_s wr_in;
  rti_pkg::rti_wr_s wr_out;
  logic             fifo_in_valid;
  logic             fifo_in_ready;

  rti_fifo #(
    .WIDTH ($bits(rti_pkg::rti_wr_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_in),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_out)
  );

  assign wr_addr = wr_out.addr;
  assign wr_data = wr_out.data;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  rti_pkg::rti_state_e state;
  logic [3:0]          bit_cnt;
  logic [7:0]          shreg;
  logic [7:0]          ptr;
  logic                is_read;
  logic                have_ptr;
  logic                is_addr_byte;
  logic                ack_low;
  logic                byte_done;

  // Bits are counted on rising clock edges, so the falling edge that
  // closes a start condition is never taken for a data bit.
  assign byte_done = scl_fall && bit_cnt == 4'(rti_pkg::BITS_BYTE);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state        <= rti_pkg::ST_IDLE;
      bit_cnt      <= '0;
      shreg        <= '0;
      is_read      <= 1'b0;
      have_ptr     <= 1'b0;
      is_addr_byte <= 1'b0;
      ack_low      <= 1'b0;
    end
    else if (start_cond)
    begin
      // Repeated start is handled exactly like a first start.
      state        <= rti_pkg::ST_ADDR;
      bit_cnt      <= '0;
      ack_low      <= 1'b0;
      have_ptr     <= 1'b0;
    end
    else if (stop_cond)
    begin
      state   <= rti_pkg::ST_IDLE;
      ack_low <= 1'b0;
    end
    else
    begin
      unique case (state)
        rti_pkg::ST_IDLE:
          ack_low <= 1'b0;
        rti_pkg::ST_ADDR, rti_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            shreg   <= {shreg[6:0], pins.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done)
          begin
            bit_cnt <= '0;
            if (state == rti_pkg::ST_ADDR)
            begin
              if (shreg[7:1] == rti_pkg::TARGET_ADDR)
              begin
                is_read      <= shreg[0] == rti_pkg::DIR_READ;
                is_addr_byte <= 1'b1;
                ack_low      <= 1'b1;
                state        <= rti_pkg::ST_ACK;
              end
              else
                state <= rti_pkg::ST_WAIT_STOP;
            end
            else
            begin
              is_addr_byte <= 1'b0;
              ack_low      <= have_ptr ? fifo_in_ready : 1'b1;
              state        <= rti_pkg::ST_ACK;
            end
          end
        end
        rti_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            ack_low <= 1'b0;
            if (is_addr_byte && is_read)
              state <= rti_pkg::ST_TX;
            else if (!is_addr_byte && !have_ptr)
            begin
              have_ptr <= 1'b1;
              state    <= rti_pkg::ST_RX;
            end
            else
              state <= rti_pkg::ST_RX;
          end
        end
        rti_pkg::ST_TX:
        begin
          if (byte_done)
          begin
            bit_cnt <= '0;
            state   <= rti_pkg::ST_TX_ACK;
          end
          else if (scl_rise)
            bit_cnt <= bit_cnt + 4'h1;
        end
        rti_pkg::ST_TX_ACK:
        begin
          if (scl_rise)
            is_addr_byte <= pins.sda;
          if (scl_fall)
            state <= is_addr_byte ? rti_pkg::ST_WAIT_STOP
                                  : rti_pkg::ST_TX;
        end
        rti_pkg::ST_WAIT_STOP:
          ack_low <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register pointer and write capture
  // ----------------------------------------------------------------
  logic ptr_load;
  logic wr_push;

  assign ptr_load = state == rti_pkg::ST_ACK && scl_fall
                    && !is_addr_byte && !have_ptr;
  assign wr_push  = state == rti_pkg::ST_ACK && scl_fall
                    && !is_addr_byte && have_ptr && ack_low;

  always_ff @(posedge clk)
  begin
    if (rst)
      ptr <= rti_pkg::PTR_RESET;
    else if (ptr_load)
      ptr <= shreg;
    else if (wr_push)
      ptr <= ptr + 8'h01;
    else if (state == rti_pkg::ST_TX_ACK && scl_fall)
      ptr <= ptr + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wr_in <= '0;
    else if (wr_push)
    begin
      wr_in.addr <= ptr;
      wr_in.data <= shreg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      fifo_in_valid <= 1'b0;
    else
      fifo_in_valid <= wr_push && fifo_in_ready;
  end

  // ----------------------------------------------------------------
  // Data line drive
  // ----------------------------------------------------------------
  logic [7:0] tx_byte;
  logic       tx_low;

  always_ff @(posedge clk)
  begin
    if (rst)
      tx_byte <= '1;
    else if (state == rti_pkg::ST_ACK && scl_fall && is_addr_byte)
      tx_byte <= rd_data;
    else if (state == rti_pkg::ST_TX_ACK && scl_fall)
      tx_byte <= rd_data;
    else if (state == rti_pkg::ST_TX && scl_fall)
      tx_byte <= {tx_byte[6:0], 1'b1};                // MSB first
  end

  assign rd_addr = state == rti_pkg::ST_TX_ACK ? ptr + 8'h01 : ptr;

  always_ff @(posedge clk)
  begin
    if (rst)
      tx_low <= 1'b0;
    else if (state == rti_pkg::ST_TX && !byte_done)
      tx_low <= !tx_byte[7];
    else
      tx_low <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sda_oe_n <= 1'b1;
    else
      sda_oe_n <= !((ack_low && state == rti_pkg::ST_ACK) || tx_low);
  end

  assign sda_out = 1'b0;

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      test_access <= 1'b0;
    else
      test_access <= rd_addr == rti_pkg::TEST_ADDR_LO
                     || rd_addr == rti_pkg::TEST_ADDR_HI;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= state != rti_pkg::ST_IDLE;
  end

endmodule : rti_target

`default_nettype wire

// file: testbench/rti_target_asserts.sv
// Checker for pin timing and write-port behaviour of the target.
`timescale 1ns/100ps
`default_nettype none

module rti_target_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       test_access,
  input wire logic       busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence

  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence

  chk_drive_low:
    assert property (!sda_oe_n |-> !sda_out)
    else $error("Data pin enabled with high value");
  chk_hold_high:
    assert property (scl_in && $past(scl_in) && $past(scl_in, 2)
                     |-> $stable(sda_oe_n))
    else $error("Data drive changed while clock high");
  chk_edge_low:
    assert property ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in, 3))
    else $error("Data drive began outside clock low");
  chk_idle_free:
    assert property (!busy && !$past(busy) |-> sda_oe_n)
    else $error("Data pin driven while idle");
  chk_start_busy:
    assert property (s_start |-> ##[1:8] busy)
    else $error("Start not followed by busy");
  chk_stop_idle:
    assert property (s_stop |-> ##[1:8] !busy)
    else $error("Stop not followed by idle");
  chk_fifo_hold:
    assert property (wr_valid && !wr_ready |=> wr_valid
                     && $stable(wr_addr) && $stable(wr_data))
    else $error("Write entry changed before taken");
  chk_test_flag:
    assert property (($stable(rd_addr)) [*2] |-> test_access ==
                     (rd_addr == rti_pkg::TEST_ADDR_LO
                      || rd_addr == rti_pkg::TEST_ADDR_HI))
    else $error("Test flag disagrees with pointer");
endmodule : rti_target_asserts

bind rti_target rti_target_asserts u_chk (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
  .rd_addr(rd_addr), .rd_data(rd_data), .test_access(test_access),
  .busy(busy)
);

`default_nettype wire

// file: testbench/rti_ctrl_model.sv
// Bus controller model driving the clock and data pins.
`timescale 1ns/100ps
`default_nettype none

module rti_ctrl_model (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_drv
);
  initial scl = 1'b1;
  initial sda_drv = 1'b1;

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w

  task automatic start(input bit re);
    if (re)
    begin
      w(4);
      sda_drv <= 1'b1;
      w(4);
      scl <= 1'b1;
      w(8);
    end
    sda_drv <= 1'b0;
    w(8);
    scl <= 1'b0;
  endtask : start

  task automatic stop;
    w(4);
    sda_drv <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(8);
    sda_drv <= 1'b1;
    w(8);
  endtask : stop

  // One clock pulse; the line is sampled mid-way through clock high.
  task automatic pulse(input logic d, output logic s);
    w(4);
    sda_drv <= d;
    w(4);
    scl <= 1'b1;
    w(4);
    s = sda;
    w(4);
    scl <= 1'b0;
  endtask : pulse

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'b1, ack);
  endtask : send

  task automatic recv(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(1'b1, d[i]);
    pulse(nack, s);
  endtask : recv
endmodule : rti_ctrl_model

`default_nettype wire

// file: testbench/rti_target_tb.sv
// Self-checking bench for the serial register target.
`timescale 1ns/100ps
`default_nettype none

module rti_target_tb;
  logic       clk = 1'b0;
  logic       rst;
  logic       wr_ready;
  logic [7:0] rd_data;
  logic       scl;
  logic       sda_drv;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe_n;
  logic       wr_valid;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic       test_access;
  logic       busy;
  int         err_count;
  int         n_tests;

  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  rti_target dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .test_access(test_access),
    .busy(busy)
  );

  rti_ctrl_model model (
    .clk(clk), .sda(sda_line), .scl(scl), .sda_drv(sda_drv)
  );

  always #5 clk = ~clk;

  always @(posedge clk) rd_data <= rd_addr ^ 8'h5A;

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("Mismatches %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic pop(input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    #1;
    while (wr_valid !== 1'b1 && i < 50)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    check("wr_valid", {7'h00, wr_valid}, 8'h01);
    if (wr_valid !== 1'b1)
      give_verdict();
    check("wr_addr", wr_addr, a);
    check("wr_data", wr_data, d);
    @(posedge clk);
    wr_ready <= 1'b1;
    @(posedge clk);
    wr_ready <= 1'b0;
  endtask : pop

  // Nine bytes into a stalled consumer: eight fit, the ninth is refused.
  task automatic sc_fill;
    logic ack;
    model.start(1'b0);
    model.send(8'hD0, ack);
    check("wr_sel_ack", {7'h00, ack}, 8'h00);
    model.send(8'h10, ack);
    for (int i = 0; i < 9; i++)
    begin
      model.send(8'hA0 + 8'(i), ack);
      check("data_ack", {7'h00, ack}, {7'h00, i == 8});
    end
    model.stop();
    check("ptr", rd_addr, 8'h18);
    check("test_off", {7'h00, test_access}, 8'h00);
    for (int i = 0; i < 8; i++)
      pop(8'h10 + 8'(i), 8'hA0 + 8'(i));
    #1;
    check("empty", {7'h00, wr_valid}, 8'h00);
  endtask : sc_fill

  task automatic sc_wrong;
    logic ack;
    model.start(1'b0);
    model.send(8'hD2, ack);
    check("other_ack", {7'h00, ack}, 8'h01);
    model.send(8'h00, ack);
    check("other_data", {7'h00, ack}, 8'h01);
    model.stop();
    check("ptr_kept", rd_addr, 8'h18);
  endtask : sc_wrong

  task automatic sc_read;
    logic       ack;
    logic [7:0] d;
    model.start(1'b0);
    model.send(8'hD0, ack);
    model.send(8'h20, ack);
    model.start(1'b1);
    model.send(8'hD1, ack);
    check("rd_sel_ack", {7'h00, ack}, 8'h00);
    model.recv(1'b0, d);
    check("rd_first", d, 8'h7A);
    model.recv(1'b1, d);
    check("rd_next", d, 8'h7B);
    repeat (6) @(posedge clk);
    #1;
    check("released", {7'h00, sda_oe_n}, 8'h01);
    model.stop();
    model.start(1'b0);
    model.send(8'hD1, ack);
    model.recv(1'b1, d);
    check("rd_simple", d, 8'h78);
    model.stop();
    model.start(1'b0);
    model.send(8'hD0, ack);
    model.send(rti_pkg::TEST_ADDR_LO, ack);
    model.stop();
    check("test_on", {7'h00, test_access}, 8'h01);
  endtask : sc_read

  initial
  begin
    rst = 1'b1;
    wr_ready = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    sc_fill();
    sc_wrong();
    sc_read();
    give_verdict();
  end
endmodule : rti_target_tb

`default_nettype wire
